// *** src/lftpc_core.sv ***
// protocol control of a low-frequency read/write transponder
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ns

// Contract
// (RULE1) regular read loops byte 0 to last byte
// (RULE2) last byte 15, else 7 biphase, 11 two-tone
// (RULE3) data lock codes enter regular read
// (RULE4) every read mode entry sends zero first
// (RULE5) direct access repeats addressed byte
// (RULE6) all-zero lock code sends zero bits
// (RULE7) gap spacing 25 means zero, 58 one
// (RULE8) no gap within 64 clocks ends command
// (RULE9) wrong count or error abandons to read
// (RULE10) start gap accepted after 1ms startup
// (RULE11) reader may lengthen the start gap
// (RULE12) opcode 00 reruns initialisation
// (RULE13) opcode 10 alone reads the identifier
// (RULE14) opcode 11 reads upper bytes or identifier
// (RULE15) write byte is sixteen bits long
// (RULE16) direct access is eight bits long
// (RULE17) stored bits go out in received order
// (RULE18) delay precedes programming after write
// (RULE19) programming about 5.6ms, then byte read
// (RULE20) erase, verify zero, program, verify ones
// (RULE21) bad spacing or bit count flags error
// (RULE22) locked write skips programming, byte read
// (RULE23) failed verify silences until next command
// (RULE24) lock field is bits 1 to 5; the code takes the lock field from cfg bits 3 to 7 (LOCK_LSB to LOCK_MSB)
// (RULE25) uplink rate 50 or 32 field clocks
// (RULE26) all timing counts extracted field clocks
module lftpc_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rf_clk_i,
    input wire logic gap_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output lftpc_pkg::lftpc_uplink_s uplink_o
);
    import lftpc_pkg::*;

    function automatic lftpc_read_e lock_kind(input logic [7:0] cfg);
        lock_kind = (cfg[LOCK_MSB:LOCK_LSB] == LOCK_OPEN_DUMMY) ?
                    RD_DUMMY : RD_REGULAR;
    endfunction : lock_kind

    logic rf_s1_reg, rf_s2_reg, rf_s3_reg;
    logic gap_s1_reg, gap_s2_reg, gap_s3_reg;
    logic [7:0] mem_reg [0:MEM_BYTES-1];
    logic [7:0] ctrl_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    lftpc_state_e state_reg, state_next;
    lftpc_read_e rd_kind_reg, rd_kind_next;
    logic [4:0] tx_byte_reg, tx_byte_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic lead_zero_reg, lead_zero_next;
    logic [5:0] rate_cnt_reg, rate_cnt_next;
    logic [9:0] phase_reg, phase_next;
    logic [9:0] su_cnt_reg;
    logic ready_reg;
    logic [6:0] spacing_reg, spacing_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [15:0] cmd_reg, cmd_next;
    logic rx_err_reg, rx_err_next;
    logic cmd_err_reg, cmd_err_next;
    logic [4:0] wr_addr_reg, wr_addr_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic [7:0] cfg_reg, cfg_next;
    lftpc_uplink_s uplink_reg, uplink_next;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic go_read;
    lftpc_read_e go_kind;
    logic [4:0] go_byte;
    logic tx_emit;

    // link edges: first stage feeds only the second
    always_ff @(posedge clk_i) begin
        rf_s1_reg <= rf_clk_i;
        rf_s2_reg <= rf_s1_reg;
        rf_s3_reg <= rf_s2_reg;
        gap_s1_reg <= gap_i;
        gap_s2_reg <= gap_s1_reg;
        gap_s3_reg <= gap_s2_reg;
    end

    wire fclk_tick = rf_s2_reg & ~rf_s3_reg; // RULE26
    // any gap length is taken, so a long start gap is harmless
    wire gap_start = gap_s2_reg & ~gap_s3_reg; // RULE11
    wire rx_go = gap_start & ready_reg; // RULE10

    // configuration decode
    wire [4:0] lock_field = cfg_reg[LOCK_MSB:LOCK_LSB]; // RULE24
    wire locked = (lock_field == LOCK_CLOSED);
    wire span_full = cfg_reg[SPAN_BIT];
    wire two_tone = cfg_reg[FSK_BIT];
    wire [4:0] last_byte = span_full ? LAST_FULL :
                           (two_tone ? LAST_TWO_TONE : LAST_BIPHASE); // RULE2
    wire [4:0] upper_start = last_byte + 5'd1;
    wire [5:0] bit_period = two_tone ? RATE_SLOW : RATE_FAST; // RULE25
    wire force_fail = ctrl_reg[0];

    // downlink bit classification
    wire is_zero = (spacing_reg >= ZERO_MIN) && (spacing_reg <= ZERO_MAX);
    wire is_one = (spacing_reg >= ONE_MIN) && (spacing_reg <= ONE_MAX);
    wire rx_timeout = fclk_tick && (spacing_reg == RX_TIMEOUT_FCLK);

    // command decode, valid only with the matching bit count
    wire is_reset = (bit_cnt_reg == BITS_SHORT) &&
                    (cmd_reg[1:0] == 2'b00); // RULE12
    wire is_read_id = (bit_cnt_reg == BITS_SHORT) &&
                      (cmd_reg[1:0] == 2'b10); // RULE13
    wire is_upper = (bit_cnt_reg == BITS_SHORT) &&
                    (cmd_reg[1:0] == 2'b11); // RULE14
    wire is_direct = (bit_cnt_reg == BITS_DIRECT) &&
                     (cmd_reg[7:5] == 3'b100) &&
                     (cmd_reg[4:0] <= MAX_ADDR); // RULE16
    wire is_write = (bit_cnt_reg == BITS_WRITE) &&
                    (cmd_reg[15:13] == 3'b100) &&
                    (cmd_reg[4:0] <= MAX_ADDR); // RULE15
    wire cmd_ok = !rx_err_reg &&
                  (is_reset || is_read_id || is_upper ||
                   is_direct || is_write); // RULE9 RULE21

    // read path stepping
    wire rate_end = (rate_cnt_reg == bit_period - 6'd1);
    wire [4:0] end_byte = (rd_kind_reg == RD_UPPER) ? LAST_FULL :
                          (rd_kind_reg == RD_BYTE) ? tx_byte_reg : last_byte;
    wire [4:0] wrap_byte = (rd_kind_reg == RD_UPPER) ? upper_start :
                           (rd_kind_reg == RD_BYTE) ? tx_byte_reg : 5'd0;
    // first received bit is bit 1, stored at the top of the byte
    wire mem_bit = mem_reg[tx_byte_reg][3'd7 - tx_bit_reg]; // RULE17
    wire step_end = fclk_tick && (phase_reg == STEP_FCLK - 10'd1);
    wire [7:0] wr_target = mem_reg[wr_addr_reg];
    assign tx_emit = (state_reg == ST_READ) && !rx_go && fclk_tick && rate_end;

    always_comb begin
        state_next = state_reg;
        rd_kind_next = rd_kind_reg;
        tx_byte_next = tx_byte_reg;
        tx_bit_next = tx_bit_reg;
        lead_zero_next = lead_zero_reg;
        rate_cnt_next = rate_cnt_reg;
        phase_next = phase_reg;
        spacing_next = spacing_reg;
        bit_cnt_next = bit_cnt_reg;
        cmd_next = cmd_reg;
        rx_err_next = rx_err_reg;
        cmd_err_next = cmd_err_reg;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        cfg_next = cfg_reg;
        uplink_next = '{mod_en: uplink_reg.mod_en, data: uplink_reg.data,
                        strobe: 1'b0};
        mem_we = 1'b0;
        mem_wdata = 8'h00;
        go_read = 1'b0;
        go_kind = RD_REGULAR;
        go_byte = 5'd0;
        if (fclk_tick && (state_reg == ST_DELAY || state_reg == ST_ERASE ||
            state_reg == ST_EVFY || state_reg == ST_PROG ||
            state_reg == ST_PVFY || state_reg == ST_INIT)) begin
            phase_next = phase_reg + 10'd1;
        end
        case (state_reg)
            ST_INIT: begin
                uplink_next.mod_en = 1'b0;
                if (fclk_tick && phase_reg == INIT_FCLK - 10'd1) begin
                    cfg_next = mem_reg[CFG_BYTE];
                    go_read = 1'b1;
                    go_kind = lock_kind(mem_reg[CFG_BYTE]); // RULE3 RULE6
                end
            end
            ST_READ: begin
                uplink_next.mod_en = 1'b1;
                if (rx_go) begin
                    state_next = ST_RX;
                end else if (fclk_tick && !rate_end) begin
                    rate_cnt_next = rate_cnt_reg + 6'd1;
                end else if (tx_emit) begin
                    rate_cnt_next = 6'd0;
                    uplink_next.strobe = 1'b1;
                    uplink_next.data = !lead_zero_reg &&
                                       (rd_kind_reg != RD_DUMMY) &&
                                       mem_bit; // RULE4 RULE6
                    lead_zero_next = 1'b0;
                    if (!lead_zero_reg) begin
                        tx_bit_next = tx_bit_reg + 3'd1;
                        if (tx_bit_reg == 3'd7) begin
                            if (tx_byte_reg == end_byte) begin
                                tx_byte_next = wrap_byte; // RULE1 RULE5
                                cfg_next = mem_reg[CFG_BYTE];
                            end else begin
                                tx_byte_next = tx_byte_reg + 5'd1; // RULE1
                            end
                        end
                    end
                end
            end
            ST_RX: begin
                uplink_next.mod_en = 1'b0;
                if (gap_start) begin
                    spacing_next = 7'd0;
                    cmd_next = {cmd_reg[14:0], is_one}; // RULE7
                    if (!is_zero && !is_one) begin
                        rx_err_next = 1'b1; // RULE21
                    end
                    if (bit_cnt_reg != BITS_SAT) begin
                        bit_cnt_next = bit_cnt_reg + 5'd1;
                    end
                end else if (rx_timeout) begin // RULE8
                    phase_next = 10'd0;
                    if (!cmd_ok) begin
                        cmd_err_next = 1'b1;
                        go_read = 1'b1;
                        go_kind = lock_kind(cfg_reg); // RULE9
                    end else if (is_reset) begin
                        state_next = ST_INIT;
                    end else if (is_read_id ||
                                 (is_upper && span_full)) begin
                        go_read = 1'b1; // RULE13 RULE14
                    end else if (is_upper) begin
                        go_read = 1'b1;
                        go_kind = RD_UPPER;
                        go_byte = upper_start;
                    end else if (is_direct) begin
                        go_read = 1'b1;
                        go_kind = RD_BYTE; // RULE5
                        go_byte = cmd_reg[4:0];
                    end else begin
                        wr_addr_next = cmd_reg[4:0];
                        wr_data_next = cmd_reg[12:5];
                        if (locked) begin
                            go_read = 1'b1;
                            go_kind = RD_BYTE; // RULE22
                            go_byte = cmd_reg[4:0];
                        end else begin
                            state_next = ST_DELAY;
                        end
                    end
                end else if (fclk_tick) begin
                    spacing_next = spacing_reg + 7'd1;
                end
            end
            ST_DELAY: begin
                if (fclk_tick && phase_reg == WRITE_DELAY_FCLK - 10'd1) begin
                    phase_next = 10'd0;
                    state_next = ST_ERASE; // RULE18
                end
            end
            ST_ERASE: begin
                if (step_end) begin
                    phase_next = 10'd0;
                    mem_we = 1'b1;
                    state_next = ST_EVFY; // RULE20
                end
            end
            ST_EVFY: begin
                if (step_end) begin
                    phase_next = 10'd0;
                    state_next = (wr_target != 8'h00 || force_fail) ?
                                 ST_SILENT : ST_PROG; // RULE20
                end
            end
            ST_PROG: begin
                if (step_end) begin
                    phase_next = 10'd0;
                    mem_we = 1'b1;
                    mem_wdata = wr_data_reg;
                    state_next = ST_PVFY; // RULE19
                end
            end
            ST_PVFY: begin
                if (step_end) begin
                    phase_next = 10'd0;
                    if (((wr_target & wr_data_reg) != wr_data_reg) ||
                        force_fail) begin
                        state_next = ST_SILENT; // RULE23
                    end else begin
                        go_read = 1'b1;
                        go_kind = RD_BYTE; // RULE19
                        go_byte = wr_addr_reg;
                    end
                end
            end
            ST_SILENT: begin
                uplink_next.mod_en = 1'b0; // RULE23
                if (rx_go) begin
                    state_next = ST_RX;
                end
            end
            default: begin
                state_next = ST_INIT;
            end
        endcase
        if (rx_go && (state_reg == ST_READ || state_reg == ST_SILENT)) begin
            spacing_next = 7'd0;
            bit_cnt_next = 5'd0;
            rx_err_next = 1'b0;
            cmd_err_next = 1'b0;
            uplink_next.mod_en = 1'b0;
        end
        if (go_read) begin
            state_next = ST_READ;
            rd_kind_next = go_kind;
            tx_byte_next = go_byte;
            tx_bit_next = 3'd0;
            lead_zero_next = 1'b1; // RULE4
            rate_cnt_next = 6'd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_INIT;
            rd_kind_reg <= RD_REGULAR;
            tx_byte_reg <= 5'd0;
            tx_bit_reg <= 3'd0;
            lead_zero_reg <= 1'b1;
            rate_cnt_reg <= 6'd0;
            phase_reg <= 10'd0;
            spacing_reg <= 7'd0;
            bit_cnt_reg <= 5'd0;
            cmd_reg <= 16'h0000;
            rx_err_reg <= 1'b0;
            cmd_err_reg <= 1'b0;
            wr_addr_reg <= 5'd0;
            wr_data_reg <= 8'h00;
            cfg_reg <= CFG_RESET;
            uplink_reg <= '0;
        end else begin
            state_reg <= state_next;
            rd_kind_reg <= rd_kind_next;
            tx_byte_reg <= tx_byte_next;
            tx_bit_reg <= tx_bit_next;
            lead_zero_reg <= lead_zero_next;
            rate_cnt_reg <= rate_cnt_next;
            phase_reg <= phase_next;
            spacing_reg <= spacing_next;
            bit_cnt_reg <= bit_cnt_next;
            cmd_reg <= cmd_next;
            rx_err_reg <= rx_err_next;
            cmd_err_reg <= cmd_err_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            cfg_reg <= cfg_next;
            uplink_reg <= uplink_next;
        end
    end

    // startup window before the first start gap is honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            su_cnt_reg <= 10'd0;
            ready_reg <= 1'b0;
        end else if (fclk_tick && !ready_reg) begin
            su_cnt_reg <= su_cnt_reg + 10'd1;
            ready_reg <= (su_cnt_reg == STARTUP_FCLK - 10'd1); // RULE10
        end
    end

    // wishbone slave: registered ack, write lands on the ack edge
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_wr = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    wire [5:0] bus_idx = wb_adr_i[7:2];
    wire bus_mem = (bus_idx >= IDX_MEM0) && (bus_idx <= IDX_MEM_LAST);
    wire [5:0] bus_off = bus_idx - IDX_MEM0;
    wire [4:0] bus_mem_idx = bus_off[4:0];
    wire [31:0] status_word = {13'h0000, cmd_err_reg, ready_reg,
                               rd_kind_reg, cfg_reg, 3'h0, state_reg};
    wire [31:0] rd_word = (bus_idx == IDX_CTRL) ? {24'h000000, ctrl_reg} :
                          (bus_idx == IDX_STATUS) ? status_word :
                          bus_mem ? {24'h000000, mem_reg[bus_mem_idx]} :
                          32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            ctrl_reg <= CTRL_RESET;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            dat_reg <= rd_word;
            if (bus_wr && bus_idx == IDX_CTRL) begin
                ctrl_reg <= wb_dat_i[7:0];
            end
        end
    end

    // programming has priority over the software backdoor
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_reg[wr_addr_reg] <= mem_wdata;
        end else if (bus_wr && bus_mem) begin
            mem_reg[bus_mem_idx] <= wb_dat_i[7:0];
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign uplink_o = uplink_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_WRAP_TO_ZERO: assert property ( // RULE1
        (tx_emit && rd_kind_reg == RD_REGULAR && !lead_zero_reg &&
         tx_bit_reg == 3'd7 && tx_byte_reg == last_byte)
        |=> (tx_byte_reg == 5'd0) && (tx_bit_reg == 3'd0))
        else $error("regular read did not wrap to byte 0");
    AST_SHORT_SPAN: assert property ( // RULE2
        (state_reg == ST_READ && rd_kind_reg == RD_REGULAR &&
         !span_full && !two_tone) |-> (tx_byte_reg <= 5'd7))
        else $error("short biphase span passed byte 7");
    AST_LEAD_ZERO: assert property ( // RULE4
        (tx_emit && lead_zero_reg) |=> uplink_reg.strobe && !uplink_reg.data
        ##1 !lead_zero_reg)
        else $error("read entry did not send a zero first");
    AST_DUMMY_ZERO: assert property ( // RULE6
        (tx_emit && rd_kind_reg == RD_DUMMY) |=> !uplink_reg.data)
        else $error("dummy read sent a one");
    AST_TIMEOUT: assert property ( // RULE8
        (state_reg == ST_RX && rx_timeout && !gap_start)
        |=> state_reg != ST_RX)
        else $error("downlink did not end after 64 field clocks");
    AST_BAD_GAP: assert property ( // RULE21
        (state_reg == ST_RX && gap_start && !is_zero && !is_one)
        |=> rx_err_reg [*2])
        else $error("bad gap spacing not flagged");
    AST_LOCKED_WRITE: assert property ( // RULE22
        (state_reg == ST_RX && rx_timeout && cmd_ok && is_write && locked)
        |=> state_reg == ST_READ && rd_kind_reg == RD_BYTE &&
            tx_byte_reg == $past(cmd_reg[4:0]))
        else $error("locked write did not fall back to byte read");
    AST_SILENT: assert property ( // RULE23
        (state_reg == ST_SILENT && !rx_go) |=> !uplink_reg.mod_en)
        else $error("modulation while silenced");
    AST_NOT_READY: assert property ( // RULE10
        (!ready_reg && gap_start && state_reg != ST_RX)
        |=> state_reg != ST_RX)
        else $error("start gap taken before startup");
    AST_RATE: assert property ( // RULE25
        (state_reg == ST_READ) |-> rate_cnt_reg < bit_period)
        else $error("bit period counter overran");

    COV_WRITE_OK: cover property (
        state_reg == ST_PVFY ##1 state_reg == ST_READ);
    COV_SILENT: cover property (state_reg == ST_SILENT);
    COV_DIRECT: cover property (
        state_reg == ST_RX && rx_timeout && cmd_ok && is_direct);
    COV_CMD_ERR: cover property ($rose(cmd_err_reg));

endmodule : lftpc_core

// *** common/lftpc_pkg.sv ***
// package of constants and types for the lf tag protocol control block
package lftpc_pkg;

    // field clock timing, one field clock nominally 8000 ns
    localparam int FIELD_PERIOD_NS = 8000;
    localparam int STARTUP_US = 1000;
    localparam int PROG_TIME_NS = 5600000;
    localparam int PROG_STEPS = 4;
    localparam logic [9:0] STARTUP_FCLK =
        10'((STARTUP_US * 1000 + FIELD_PERIOD_NS - 1) / FIELD_PERIOD_NS);
    localparam logic [9:0] STEP_FCLK =
        10'(PROG_TIME_NS / (PROG_STEPS * FIELD_PERIOD_NS));
    localparam logic [9:0] INIT_FCLK = 10'd98;
    localparam logic [9:0] WRITE_DELAY_FCLK = 10'd16;

    // gap spacing windows and timeout, in field clocks
    localparam logic [6:0] ZERO_MIN = 7'd18;
    localparam logic [6:0] ZERO_MAX = 7'd33;
    localparam logic [6:0] ONE_MIN = 7'd50;
    localparam logic [6:0] ONE_MAX = 7'd65;
    localparam logic [6:0] RX_TIMEOUT_FCLK = 7'd64;

    // uplink bit periods
    localparam logic [5:0] RATE_FAST = 6'd32;
    localparam logic [5:0] RATE_SLOW = 6'd50;

    // memory layout and configuration byte fields
    localparam int MEM_BYTES = 17;
    localparam logic [4:0] CFG_BYTE = 5'd16;
    localparam logic [4:0] MAX_ADDR = 5'd16;
    localparam int LOCK_MSB = 7;
    localparam int LOCK_LSB = 3;
    localparam int FSK_BIT = 1;
    localparam int SPAN_BIT = 0;
    localparam logic [4:0] LOCK_OPEN_DUMMY = 5'h00;
    localparam logic [4:0] LOCK_OPEN_DATA = 5'h01;
    localparam logic [4:0] LOCK_CLOSED = 5'h0D;
    localparam logic [4:0] LAST_FULL = 5'd15;
    localparam logic [4:0] LAST_BIPHASE = 5'd7;
    localparam logic [4:0] LAST_TWO_TONE = 5'd11;
    localparam logic [7:0] CFG_RESET = 8'h09;

    // command bit counts
    localparam logic [4:0] BITS_SHORT = 5'd2;
    localparam logic [4:0] BITS_DIRECT = 5'd8;
    localparam logic [4:0] BITS_WRITE = 5'd16;
    localparam logic [4:0] BITS_SAT = 5'd17;

    // wishbone word indices
    localparam logic [5:0] IDX_CTRL = 6'd0;
    localparam logic [5:0] IDX_STATUS = 6'd1;
    localparam logic [5:0] IDX_MEM0 = 6'd16;
    localparam logic [5:0] IDX_MEM_LAST = 6'd32;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_READ = 4'h1,
        ST_RX = 4'h2,
        ST_DELAY = 4'h3,
        ST_ERASE = 4'h4,
        ST_EVFY = 4'h5,
        ST_PROG = 4'h6,
        ST_PVFY = 4'h7,
        ST_SILENT = 4'h8
    } lftpc_state_e;

    typedef enum logic [1:0] {
        RD_REGULAR = 2'h0,
        RD_BYTE = 2'h1,
        RD_DUMMY = 2'h2,
        RD_UPPER = 2'h3
    } lftpc_read_e;

    typedef struct packed {
        logic mod_en;
        logic data;
        logic strobe;
    } lftpc_uplink_s;

endpackage : lftpc_pkg

// *** verif/lftpc_reader.sv ***
// reader model: free-running field clock and pulse-interval gaps
`timescale 1ns/1ns
module lftpc_reader (
    input wire logic clk_i,
    output logic rf_clk_o,
    output logic gap_o
);
    logic [1:0] div_reg = 2'h0;
    initial rf_clk_o = 1'b0;
    initial gap_o = 1'b0;
    // the carrier never stops, so the field clock runs free (800 ns)
    always @(posedge clk_i) begin
        div_reg <= div_reg + 2'h1;
        if (div_reg == 2'h3) rf_clk_o <= ~rf_clk_o;
    end
    task automatic fclk(input int n);
        repeat (n) @(posedge rf_clk_o);
    endtask : fclk
    task automatic pulse(input int len, input int sp);
        gap_o <= 1'b1;
        fclk(len);
        gap_o <= 1'b0;
        fclk(sp - len);
    endtask : pulse
    function automatic int spc(input logic b);
        return b ? 58 : 25;
    endfunction : spc
    // msb first; longer start gap, then silence past the timeout
    task automatic send_cmd(input logic [15:0] bits, input int n);
        pulse(15, spc(bits[n-1]));
        for (int i = n - 1; i > 0; i--) pulse(10, spc(bits[i-1]));
        pulse(10, 70);
    endtask : send_cmd
endmodule : lftpc_reader

// *** verif/test_lf_tag_protocol_control.sv ***
// self-checking bench of the protocol control core
`timescale 1ns/1ns
module test_lf_tag_protocol_control;
    import lftpc_pkg::*;
    logic clk_i, rst_i, rf_clk, gap, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, v;
    logic [8:0] bits;
    lftpc_uplink_s up;
    int n_errors = 0;
    int cmp_count = 0;
    lftpc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .rf_clk_i(rf_clk),
        .gap_i(gap), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .uplink_o(up));
    lftpc_reader u_rdr (.clk_i(clk_i), .rf_clk_o(rf_clk), .gap_o(gap));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // status poll; the watchdog cuts a hang
    task automatic wait_state(input logic [3:0] st);
        do wb(1'b0, 8'h04, 8'h00); while (v[3:0] !== st);
    endtask : wait_state
    // collect a fresh zero bit plus eight data bits from the uplink
    task automatic grab;
        for (int k = 0; k < 9; k++) begin
            do @(posedge clk_i); while (up.strobe !== 1'b1);
            bits = {bits[7:0], up.data};
        end
    endtask : grab
    task automatic stop_test;
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        #(80000 * 100);
        n_errors++;
        stop_test();
    end
    initial begin
        {cyc, stb, we, adr, wdat} = '0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int n = 0; n < 16; n++) wb(1'b1, 8'(8'h40 + 4 * n), 8'(8'h10 + n));
        wb(1'b1, 8'h80, 8'h09);
        wb(1'b0, 8'h00, 8'h00);
        chk("ctrl", v, 32'h0);
        wb(1'b0, 8'h0C, 8'h00);
        chk("unmapped", v, 32'h0);
        do wb(1'b0, 8'h04, 8'h00); while (v[17] !== 1'b1);
        chk("regular", {v[16:15], v[3:0]}, 32'h01);
        u_rdr.send_cmd(16'h0083, 8);
        grab();
        chk("byte read", {23'h0, bits}, 32'h013);
        wb(1'b0, 8'h04, 8'h00);
        chk("kind", v[16:15], 32'h1);
        u_rdr.send_cmd(16'h0004, 3);
        wb(1'b0, 8'h04, 8'h00);
        chk("bad count", {v[18], v[16:15]}, 32'h4);
        u_rdr.send_cmd(16'h94A2, 16);
        wait_state(4'h1);
        wb(1'b0, 8'h48, 8'h00);
        chk("written", v, 32'h0A5);
        grab();
        chk("new byte", {23'h0, bits}, 32'h0A5);
        // forced verify failure must silence the uplink
        wb(1'b1, 8'h00, 8'h01);
        u_rdr.send_cmd(16'h94A2, 16);
        wait_state(4'h8);
        chk("silent", {v[3:0], up.mod_en}, 32'h10);
        wb(1'b1, 8'h00, 8'h00);
        // spacing of 40 is neither a zero nor a one
        u_rdr.pulse(15, 40);
        u_rdr.pulse(10, 70);
        wb(1'b0, 8'h04, 8'h00);
        chk("bad gap", {v[18], v[16:15], v[3:0]}, 32'h41);
        wb(1'b1, 8'h80, 8'h00);
        u_rdr.send_cmd(16'h0000, 2);
        wb(1'b0, 8'h04, 8'h00);
        chk("init", v[3:0], 32'h0);
        wait_state(4'h1);
        chk("dummy", v[16:15], 32'h2);
        grab();
        chk("dummy bits", {23'h0, bits}, 32'h000);
        stop_test();
    end
endmodule : test_lf_tag_protocol_control
